// ---- rtl/dsl_pkg.sv ----
`default_nettype none
package dsl_pkg;
    // register offsets, one parameter word each on the register bus
    localparam logic [11:0] QSTOP_REACT_OFS = 12'h630;
    localparam logic [11:0] LSW_RESP_OFS = 12'h60C;
    localparam logic [11:0] POS_DENOM_OFS = 12'h60E;
    localparam logic [11:0] POS_NUM_OFS = 12'h610;
    // reset values
    localparam logic [15:0] QSTOP_REACT_RST = 16'h0006;
    localparam logic [15:0] LSW_RESP_RST = 16'h0000;
    localparam logic [31:0] POS_DENOM_RST = 32'h0000_4000;
    localparam logic [31:0] POS_NUM_RST = 32'h0000_0001;
    // quick stop reaction codes
    localparam logic [15:0] QS_TORQUE_FAULT = 16'hFFFE;
    localparam logic [15:0] QS_DECEL_FAULT = 16'hFFFF;
    localparam logic [15:0] QS_DECEL_QSTOP = 16'h0006;
    localparam logic [15:0] QS_TORQUE_QSTOP = 16'h0007;
    // operating state numbers
    localparam logic [3:0] STATE_QUICK_STOP = 4'h7;
    localparam logic [3:0] STATE_FAULT = 4'h9;
    // limit switch response codes
    localparam logic [15:0] LSW_ERROR = 16'h0000;
    localparam logic [15:0] LSW_NO_ERROR = 16'h0001;
endpackage
`default_nettype wire

// ---- rtl/dsl_param_bank.sv ----
`default_nettype none
// Notes on behaviour
// [RL1] Code -2 stops on the torque ramp and then goes to fault state 9.
// [RL2] Code -1 stops on the deceleration ramp and then goes to fault state 9.
// [RL3] Code 6 stops on the deceleration ramp and stays in quick stop state 7.
// [RL4] Code 7 stops on the torque ramp and stays in quick stop state 7.
// [RL5] Writes to the quick stop code are refused while a deceleration ramp runs.
// [RL6] Ramp slope and torque limit come from separate parameters outside this bank.
// [RL7] The master writes -1 into the quick stop code at commissioning.
// [RL8] Response 0 raises an error when enabling the stage with a limit switch active.
// [RL9] Response 1 raises no error when enabling with a limit switch active.
// [RL10] The response is checked only at the enable moment against current switches.
// [RL11] The master writes 1 into the limit switch response and leaves it.
// [RL12] The master writes denominator 131072 and numerator 1 and leaves them.
// [RL13] A new position scaling becomes active only when the numerator is written.
// [RL14] Position scaling writes are accepted only with the power stage disabled.
// [RL15] Scaling is revolutions over user units, each signed 32-bit from 1 to 2147483647.
// [RL16] Refused or out-of-range writes leave the stored parameter unchanged.
module dsl_param_bank
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WR_DATA,
    output logic [31:0] RD_DATA,
    output logic WR_ACK,
    output logic WR_REFUSED,
    input wire logic QSTOP_REQ,
    input wire logic DECEL_RAMP_ACTIVE,
    input wire logic POWER_STAGE_ENABLED,
    input wire logic LIMIT_SWITCH_ACTIVE,
    output logic QSTOP_USE_TORQUE_RAMP,
    output logic QSTOP_USE_DECEL_RAMP,
    output logic [3:0] QSTOP_TARGET_STATE,
    output logic LIMIT_ENABLE_ERROR,
    output logic [31:0] ACTIVE_POS_NUM,
    output logic [31:0] ACTIVE_POS_DENOM
);
    logic [15:0] qstop_react_q;
    logic [15:0] lsw_resp_q;
    logic [31:0] pos_denom_q;
    logic [31:0] pos_num_q;
    logic [31:0] act_num_q;
    logic [31:0] act_denom_q;
    logic [31:0] rd_data_q;
    logic wr_ack_q;
    logic wr_ref_q;
    logic lim_err_q;
    logic ramp_s1_q, ramp_s2_q, pse_s1_q, pse_s2_q, lsw_s1_q, lsw_s2_q, pse_prev_q;
    // resync stages for the stop request
    logic qreq_s1_q, qreq_s2_q;
    // registered reaction outputs
    logic use_torque_q, use_decel_q;
    logic [3:0] target_q;

    // value range check for the 32-bit scaling words: 1 .. 2^31-1
    function automatic logic scale_ok(input logic [31:0] v);
        scale_ok = !v[31] && (v != 32'h0000_0000);
    endfunction
    // reaction code decode, used only by the output registers
    function automatic logic qs_is_torque(input logic [15:0] code);
        qs_is_torque = (code == dsl_pkg::QS_TORQUE_FAULT) || (code == dsl_pkg::QS_TORQUE_QSTOP);
    endfunction
    function automatic logic qs_is_fault(input logic [15:0] code);
        qs_is_fault = (code == dsl_pkg::QS_TORQUE_FAULT) || (code == dsl_pkg::QS_DECEL_FAULT);
    endfunction

    // status pins and the stop request come from the drive core's domain; resync costs two cycles of lag
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            {ramp_s1_q, ramp_s2_q, pse_s1_q, pse_s2_q, lsw_s1_q, lsw_s2_q, qreq_s1_q, qreq_s2_q} <= 8'h00;
        end
        else
        begin
            ramp_s1_q <= DECEL_RAMP_ACTIVE;
            ramp_s2_q <= ramp_s1_q;
            pse_s1_q <= POWER_STAGE_ENABLED;
            pse_s2_q <= pse_s1_q;
            lsw_s1_q <= LIMIT_SWITCH_ACTIVE;
            lsw_s2_q <= lsw_s1_q;
            qreq_s1_q <= QSTOP_REQ;
            qreq_s2_q <= qreq_s1_q;
        end
    end

    // address decode and acceptance terms
    wire hit_qs = (ADDR == dsl_pkg::QSTOP_REACT_OFS);
    wire hit_lsw = (ADDR == dsl_pkg::LSW_RESP_OFS);
    wire hit_den = (ADDR == dsl_pkg::POS_DENOM_OFS);
    wire hit_num = (ADDR == dsl_pkg::POS_NUM_OFS);
    wire [15:0] wd16 = WR_DATA[15:0];
    wire qs_code_ok = (wd16 == dsl_pkg::QS_TORQUE_FAULT) || (wd16 == dsl_pkg::QS_DECEL_FAULT) ||
                      (wd16 == dsl_pkg::QS_DECEL_QSTOP) || (wd16 == dsl_pkg::QS_TORQUE_QSTOP);
    wire lsw_code_ok = (wd16 == dsl_pkg::LSW_ERROR) || (wd16 == dsl_pkg::LSW_NO_ERROR);
    wire qs_ok = hit_qs && qs_code_ok && !ramp_s2_q; // [RL5] [RL16]
    wire lsw_ok = hit_lsw && lsw_code_ok; // [RL16]
    wire den_ok = hit_den && scale_ok(WR_DATA) && !pse_s2_q; // [RL14] [RL15] [RL16]
    wire num_ok = hit_num && scale_ok(WR_DATA) && !pse_s2_q; // [RL14] [RL15] [RL16]
    wire wr_ok = qs_ok || lsw_ok || den_ok || num_ok;
    wire enable_edge = pse_s2_q && !pse_prev_q;
    // code the bank holds after this edge, so the reaction outputs follow a write at once
    wire [15:0] qstop_react_d = (WR_EN && qs_ok) ? wd16 : qstop_react_q;

    // parameter storage; only accepted writes change a word
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            qstop_react_q <= dsl_pkg::QSTOP_REACT_RST;
            lsw_resp_q <= dsl_pkg::LSW_RESP_RST;
            pos_denom_q <= dsl_pkg::POS_DENOM_RST;
            pos_num_q <= dsl_pkg::POS_NUM_RST;
        end
        else if (WR_EN)
        begin
            if (qs_ok) qstop_react_q <= wd16;
            if (lsw_ok) lsw_resp_q <= wd16;
            if (den_ok) pos_denom_q <= WR_DATA;
            if (num_ok) pos_num_q <= WR_DATA;
        end
    end

    // active scaling latches the pending denominator only on a numerator write
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            act_num_q <= dsl_pkg::POS_NUM_RST;
            act_denom_q <= dsl_pkg::POS_DENOM_RST;
        end
        else if (WR_EN && num_ok) // [RL13]
        begin
            act_num_q <= WR_DATA;
            act_denom_q <= pos_denom_q;
        end
    end

    // limit switch check sampled only on the enable edge
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            pse_prev_q <= 1'b0;
            lim_err_q <= 1'b0;
        end
        else
        begin
            pse_prev_q <= pse_s2_q;
            if (enable_edge) // [RL10]
                lim_err_q <= lsw_s2_q && (lsw_resp_q == dsl_pkg::LSW_ERROR); // [RL8] [RL9]
            else if (!pse_s2_q)
                lim_err_q <= 1'b0;
        end
    end

    // read mux and write answer, one cycle after the strobe
    wire [31:0] rd_mux = hit_qs ? {16'h0000, qstop_react_q} :
                         hit_lsw ? {16'h0000, lsw_resp_q} :
                         hit_den ? pos_denom_q :
                         hit_num ? pos_num_q : 32'h0000_0000;
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            rd_data_q <= 32'h0000_0000;
            wr_ack_q <= 1'b0;
            wr_ref_q <= 1'b0;
        end
        else
        begin
            if (RD_EN) rd_data_q <= rd_mux;
            wr_ack_q <= WR_EN && wr_ok;
            wr_ref_q <= WR_EN && !wr_ok;
        end
    end

    // reaction decode of the code standing after this edge; slope and current limit live elsewhere
    wire qs_torque_d = qs_is_torque(qstop_react_d); // [RL1] [RL4] [RL6]
    wire qs_fault_d = qs_is_fault(qstop_react_d); // [RL1] [RL2]

    // reaction outputs come from flops so the drive core never sees a decode glitch
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            use_torque_q <= 1'b0;
            use_decel_q <= 1'b0;
            target_q <= dsl_pkg::STATE_QUICK_STOP; // reset code 6 means stay in quick stop
        end
        else
        begin
            use_torque_q <= qreq_s2_q && qs_torque_d; // [RL1] [RL4]
            use_decel_q <= qreq_s2_q && !qs_torque_d; // [RL2] [RL3]
            target_q <= qs_fault_d ? dsl_pkg::STATE_FAULT : dsl_pkg::STATE_QUICK_STOP; // [RL1] [RL3]
        end
    end
    assign QSTOP_USE_TORQUE_RAMP = use_torque_q;
    assign QSTOP_USE_DECEL_RAMP = use_decel_q;
    assign QSTOP_TARGET_STATE = target_q;
    assign LIMIT_ENABLE_ERROR = lim_err_q;
    assign ACTIVE_POS_NUM = act_num_q;
    assign ACTIVE_POS_DENOM = act_denom_q;
    assign RD_DATA = rd_data_q;
    assign WR_ACK = wr_ack_q;
    assign WR_REFUSED = wr_ref_q;

    // assertions
    a_qs_refused_ramp: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL5]
        (WR_EN && hit_qs && ramp_s2_q) |=> $stable(qstop_react_q) && WR_REFUSED)
        else $error("quick stop code written during ramp");
    a_scale_locked_on: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL14]
        (WR_EN && (hit_den || hit_num) && pse_s2_q) |=> $stable(pos_denom_q) && $stable(pos_num_q))
        else $error("scaling changed with power stage on");
    a_denom_not_active: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL13]
        !(WR_EN && num_ok) |=> $stable(act_denom_q) && $stable(act_num_q))
        else $error("active scaling changed without numerator write");
    a_num_activates: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL13]
        (WR_EN && num_ok) |=> (act_num_q == $past(WR_DATA)) && (act_denom_q == $past(pos_denom_q)))
        else $error("numerator write did not activate scaling");
    a_scale_range_ok: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL15]
        scale_ok(pos_num_q) && scale_ok(pos_denom_q))
        else $error("scaling value out of range");
    a_limit_err_set: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL8]
        (enable_edge && lsw_s2_q && lsw_resp_q == dsl_pkg::LSW_ERROR) |=> LIMIT_ENABLE_ERROR)
        else $error("limit error missed at enable");
    a_limit_no_err: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL9]
        (enable_edge && lsw_resp_q == dsl_pkg::LSW_NO_ERROR) |=> !LIMIT_ENABLE_ERROR)
        else $error("limit error raised with response 1");
    a_limit_only_edge: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL10]
        (!enable_edge && !LIMIT_ENABLE_ERROR) |=> !LIMIT_ENABLE_ERROR)
        else $error("limit error outside enable moment");
    // reaction outputs follow the synced request and the code one edge later
    a_qs_fault_path: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL2]
        (qreq_s2_q && qstop_react_d == dsl_pkg::QS_DECEL_FAULT) |=>
        QSTOP_USE_DECEL_RAMP && QSTOP_TARGET_STATE == dsl_pkg::STATE_FAULT)
        else $error("code -1 reaction wrong");
    a_qs_torque_stay: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL4]
        (qreq_s2_q && qstop_react_d == dsl_pkg::QS_TORQUE_QSTOP) |=>
        QSTOP_USE_TORQUE_RAMP && QSTOP_TARGET_STATE == dsl_pkg::STATE_QUICK_STOP)
        else $error("code 7 reaction wrong");
    a_qs_torque_fault: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL1]
        (qreq_s2_q && qstop_react_d == dsl_pkg::QS_TORQUE_FAULT) |=>
        QSTOP_USE_TORQUE_RAMP && QSTOP_TARGET_STATE == dsl_pkg::STATE_FAULT)
        else $error("code -2 reaction wrong");
    a_qs_decel_stay: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL3]
        (qreq_s2_q && qstop_react_d == dsl_pkg::QS_DECEL_QSTOP) |=>
        QSTOP_USE_DECEL_RAMP && QSTOP_TARGET_STATE == dsl_pkg::STATE_QUICK_STOP)
        else $error("code 6 reaction wrong");
    a_qs_idle_off: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL6]
        !qreq_s2_q |=> !QSTOP_USE_TORQUE_RAMP && !QSTOP_USE_DECEL_RAMP)
        else $error("ramp selected without stop request");

    // write answer in two steps: the request is judged, then one answer pulse follows
    sequence s_write_taken;
        WR_EN && wr_ok;
    endsequence
    sequence s_write_turned_down;
        WR_EN && !wr_ok;
    endsequence
    sequence s_answer_ack;
        WR_ACK && !WR_REFUSED;
    endsequence
    sequence s_answer_refused;
        WR_REFUSED && !WR_ACK;
    endsequence
    a_write_acked: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
        s_write_taken |=> s_answer_ack)
        else $error("accepted write not acknowledged");
    a_write_refused: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
        s_write_turned_down |=> s_answer_refused)
        else $error("refused write not flagged");
    a_unmapped_refused: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
        (WR_EN && !(hit_qs || hit_lsw || hit_den || hit_num)) |=> WR_REFUSED)
        else $error("unmapped write not refused");

    // stored words change only through an accepted write
    a_qs_bad_code: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
        (WR_EN && hit_qs && !qs_code_ok) |=> $stable(qstop_react_q))
        else $error("undefined quick stop code stored");
    a_lsw_bad_code: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL16]
        (WR_EN && hit_lsw && !lsw_code_ok) |=> $stable(lsw_resp_q))
        else $error("undefined limit response stored");
    a_qs_code_stored: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL5]
        (WR_EN && qs_ok) |=> qstop_react_q == $past(wd16))
        else $error("accepted quick stop code not stored");
    a_den_pending_only: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL13]
        (WR_EN && den_ok) |=> (pos_denom_q == $past(WR_DATA)) && $stable(act_denom_q))
        else $error("denominator write handled wrong");
    a_scale_accept_off: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL14]
        (WR_EN && num_ok) |=> pos_num_q == $past(WR_DATA))
        else $error("numerator not stored with stage off");

    // error level drops as soon as the stage is seen off
    a_limit_err_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RL10]
        !pse_s2_q |=> !LIMIT_ENABLE_ERROR)
        else $error("limit error held with stage off");
endmodule
`default_nettype wire

// ---- verification/dsl_master.sv ----
`default_nettype none
module dsl_master
(
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [11:0] addr,
    output logic [31:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {wr_en, rd_en, addr, wr_data} = '0;
    // one-cycle strobe; released lines show the inverse so stale values never pass as valid
    task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        {wr_en, rd_en} <= 2'b00;
        addr <= ~a;
        wr_data <= ~d;
    endtask
    // start-up values the master writes once and then leaves alone
    task automatic commission();
        op(1'b1, 12'h630, 32'h0000_FFFF);
        op(1'b1, 12'h60C, 32'h0000_0001);
        op(1'b1, 12'h60E, 32'h0002_0000);
        op(1'b1, 12'h610, 32'h0000_0001);
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_drive_stop_limit_scaling_params.sv ----
`default_nettype none
module tb_drive_stop_limit_scaling_params;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic qreq = 1'b0, decel = 1'b0, stage = 1'b0, lsw = 1'b0;
    logic wr_en, rd_en, ack, refused, use_t, use_d, lim_err;
    logic [11:0] addr;
    logic [31:0] wr_data, rd_data, act_num, act_den, rnd;
    logic [3:0] target;
    logic [15:0] codes [4] = '{16'hFFFE, 16'hFFFF, 16'h0006, 16'h0007};
    logic [31:0] exp_q [$];
    integer seed = 32'h0E984A50;
    int err_count = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    dsl_master m (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
    dsl_param_bank DUT (.REF_CLK(clk), .RST_B(rst_b), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
        .WR_DATA(wr_data), .RD_DATA(rd_data), .WR_ACK(ack), .WR_REFUSED(refused), .QSTOP_REQ(qreq),
        .DECEL_RAMP_ACTIVE(decel), .POWER_STAGE_ENABLED(stage), .LIMIT_SWITCH_ACTIVE(lsw),
        .QSTOP_USE_TORQUE_RAMP(use_t), .QSTOP_USE_DECEL_RAMP(use_d), .QSTOP_TARGET_STATE(target),
        .LIMIT_ENABLE_ERROR(lim_err), .ACTIVE_POS_NUM(act_num), .ACTIVE_POS_DENOM(act_den));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // status note: 2 means accepted, 1 refused
    task automatic w(input logic [11:0] a, input logic [31:0] d, input logic ok);
        exp_q.push_back(ok ? 32'h0000_0002 : 32'h0000_0001);
        m.op(1'b1, a, d);
    endtask
    task automatic r(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        m.op(1'b0, a, 32'h0000_0000);
    endtask
    task automatic stop_test();
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // each status pulse or read answer retires the oldest note
    always @(posedge clk)
    begin
        logic rd_t;
        rd_t = rd_en;
        #1;
        if ((ack | refused) === 1'b1) chk("write_status", {30'h0, ack, refused}, exp_q.pop_front());
        if (rd_t === 1'b1) chk("read_data", rd_data, exp_q.pop_front());
    end
    // watchdog, far beyond the roughly one hundred cycles the sequence needs
    initial
    begin
        #150000;
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        r(12'h630, 32'h0000_0006);
        r(12'h60C, 32'h0000_0000);
        r(12'h60E, 32'h0000_4000);
        r(12'h610, 32'h0000_0001);
        chk("active_den", act_den, 32'h0000_4000);
        // every code decoded while a stop is requested
        qreq <= 1'b1;
        repeat (2) @(posedge clk); // stop request crosses the sync stages first
        for (int i = 0; i < 4; i++)
        begin
            w(12'h630, {16'h0000, codes[i]}, 1'b1);
            @(negedge clk);
            chk("torque_ramp", use_t, (i == 0 || i == 3));
            chk("decel_ramp", use_d, (i == 1 || i == 2));
            chk("target", target, (i < 2) ? 32'h0000_0009 : 32'h0000_0007);
        end
        rnd = $random(seed);
        w(12'h630, {16'h0000, rnd[15:0] & 16'h7FF0 | 16'h0010}, 1'b0);
        decel <= 1'b1;
        repeat (4) @(posedge clk);
        w(12'h630, 32'h0000_0006, 1'b0);
        r(12'h630, 32'h0000_0007);
        decel <= 1'b0;
        qreq <= 1'b0;
        repeat (4) @(posedge clk);
        chk("torque_idle", use_t, 32'h0000_0000);
        // commissioning, then denominator alone must not switch scaling
        repeat (4) exp_q.push_back(32'h0000_0002);
        m.commission();
        @(negedge clk);
        chk("active_num", act_num, 32'h0000_0001);
        chk("active_den", act_den, 32'h0002_0000);
        rnd = $random(seed) & 32'h7FFF_FFFF | 32'h0000_0001;
        w(12'h60E, rnd, 1'b1);
        @(negedge clk);
        chk("active_den", act_den, 32'h0002_0000);
        w(12'h610, 32'h0000_0003, 1'b1);
        @(negedge clk);
        chk("active_num", act_num, 32'h0000_0003);
        chk("active_den", act_den, rnd);
        w(12'h60E, 32'h0000_0000, 1'b0);
        w(12'h610, rnd | 32'h8000_0000, 1'b0);
        r(12'h60E, rnd);
        // limit response is judged only at the enable moment
        w(12'h60C, 32'h0000_0000, 1'b1);
        w(12'h60C, 32'h0000_0002, 1'b0);
        lsw <= 1'b1;
        repeat (4) @(posedge clk);
        stage <= 1'b1;
        repeat (5) @(posedge clk);
        chk("limit_error", lim_err, 32'h0000_0001);
        w(12'h610, 32'h0000_0001, 1'b0);
        stage <= 1'b0;
        repeat (5) @(posedge clk);
        w(12'h60C, 32'h0000_0001, 1'b1);
        stage <= 1'b1;
        repeat (5) @(posedge clk);
        chk("limit_error", lim_err, 32'h0000_0000);
        stage <= 1'b0;
        lsw <= 1'b0;
        w(12'h60C, 32'h0000_0000, 1'b1);
        stage <= 1'b1;
        repeat (5) @(posedge clk);
        lsw <= 1'b1;
        repeat (5) @(posedge clk);
        chk("limit_error", lim_err, 32'h0000_0000);
        stage <= 1'b0;
        w(12'h600, 32'h0000_0001, 1'b0);
        r(12'h600, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("pending", exp_q.size(), 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
